// ---- pkg/vadc_pkg.sv ----
// package: constants for the video converter digital interface
package vadc_pkg;
    localparam int VADC_WORD_W = 8;                  // sample word width
    localparam int VADC_FIFO_DEPTH = 32;             // words held in fifo
    localparam int VADC_PTR_W = 5;                   // fifo pointer width
    localparam logic [7:0] VADC_CODE_MIN = 8'h00;    // bottom reference code
    localparam logic [7:0] VADC_CODE_MAX = 8'hFF;    // top reference code
    localparam logic [7:0] VADC_CODE_MID = 8'h80;    // first code of upper half
    localparam logic [7:0] VADC_WORD_RST = 8'h00;    // reset value of words
    localparam int VADC_CLK_MHZ = 200;               // system clock rate
    localparam int VADC_RATE_MAX_KSPS = 35000;       // fastest sample clock
    localparam int VADC_RATE_MIN_KSPS = 500;         // slowest sample clock
    // shortest legal sample period in system cycles (round up)
    localparam int VADC_PER_MIN_CYC =
        (VADC_CLK_MHZ * 1000 + VADC_RATE_MAX_KSPS - 1) / VADC_RATE_MAX_KSPS;
    // longest legal sample period in system cycles (round down)
    localparam int VADC_PER_MAX_CYC =
        (VADC_CLK_MHZ * 1000) / VADC_RATE_MIN_KSPS;
    localparam int VADC_LAT_FALL = 3;                // rises from sample to out
endpackage : vadc_pkg

// ---- src/vadc_fifo.sv ----
// file: parameterised valid/ready fifo for sample words
`timescale 1ns/1ps
module vadc_fifo
    import vadc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int PTR_W = 5
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    // state of the fifo
    typedef struct packed {
        logic [PTR_W-1:0] wr;   // write pointer
        logic [PTR_W-1:0] rd;   // read pointer
        logic [PTR_W:0] count;  // words held
    } vadc_fifo_type;

    vadc_fifo_type st;
    vadc_fifo_type next_st;
    logic [WIDTH-1:0] mem [DEPTH];  // word storage
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // handshakes
    assign o_in_ready = (st.count != (PTR_W+1)'(DEPTH));
    assign o_out_valid = (st.count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[st.rd];

    // next pointer values
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    // register state and storage
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wr] <= i_in_data;
        end
    end
endmodule // vadc_fifo

// ---- src/vadc_core.sv ----
// file: digital side of the two-step video converter
`timescale 1ns/1ps
module vadc_core
    import vadc_pkg::*;
(
    input wire logic i_mclk,                       // system clock
    input wire logic i_rst,                        // sync reset
    input wire logic i_sample_clk,                 // sampled sample clock
    input wire logic [7:0] i_analog_code,          // quantised input
    input wire logic [7:0] i_clamp_code,           // clamp reference code
    input wire logic i_clamp_enable_n,             // clamp enable, low on
    input wire logic i_clamp_pulse_n,              // clamp pulse, low holds
    input wire logic i_output_enable_n,            // output enable, low on
    output logic [7:0] o_sample_word,              // pin output value
    output logic [7:0] o_sample_word_oe,           // pin drive enables
    output logic o_clamp_active,                   // clamp switch closed
    output logic o_word_valid,                     // fifo word available
    input wire logic i_word_ready,                 // fifo drain ready
    output logic [7:0] o_word_data,                // fifo word
    output logic o_overflow                        // result lost, fifo full
);
    // pipeline state
    typedef struct packed {
        logic clk_d;          // last sample clock level
        logic [7:0] held;     // sampled value
        logic [3:0] coarse;   // upper comparator result
        logic [3:0] fine_src; // lower bits waiting
        logic [3:0] fine;     // lower comparator result
        logic [3:0] upper2;   // upper bits aligned
        logic [7:0] word;     // output register
        logic [2:0] vld;      // stage valid flags
        logic push;           // new word this cycle
        logic overflow;       // sticky drop flag
    } vadc_core_type;

    vadc_core_type st;
    vadc_core_type next_st;
    logic fall;
    logic rise;
    logic clamp_on;
    logic [7:0] input_level;
    logic fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////
    // edge detect and clamp path
    assign fall = st.clk_d && !i_sample_clk;
    assign rise = !st.clk_d && i_sample_clk;
    assign clamp_on = !i_clamp_enable_n && !i_clamp_pulse_n;
    assign input_level = clamp_on ? i_clamp_code : i_analog_code;
    assign o_clamp_active = clamp_on;

    // three-state drive of the word pins
    assign o_sample_word = st.word;
    assign o_sample_word_oe = {8{!i_output_enable_n}};
    assign o_overflow = st.overflow;

    ////////////////////////////////////////////////////////////////////////
    // pipeline: sample on fall, coarse on rise 1, fine on 2, out on 3
    always_comb begin
        next_st = st;
        next_st.clk_d = i_sample_clk;
        next_st.push = 1'b0;
        if (fall) begin
            // take the input level (clamp code while clamping), code is straight binary
            next_st.held = input_level;
        end
        if (rise) begin
            // shift the stages together on every rising edge
            next_st.coarse = st.held[7:4];
            next_st.fine_src = st.held[3:0];
            next_st.upper2 = st.coarse;
            next_st.fine = st.fine_src;
            next_st.word = {st.upper2, st.fine};
            next_st.vld = {st.vld[1:0], 1'b1};
            next_st.push = st.vld[2];
        end
        if (st.push && !fifo_in_ready) begin
            next_st.overflow = 1'b1;
        end
    end

    // register state
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture buffer for results
    vadc_fifo #(
        .WIDTH(VADC_WORD_W),
        .DEPTH(VADC_FIFO_DEPTH),
        .PTR_W(VADC_PTR_W)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_in_valid(st.push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(st.word),
        .o_out_valid(o_word_valid),
        .i_out_ready(i_word_ready),
        .o_out_data(o_word_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_fall;
        st.clk_d && !i_sample_clk;
    endsequence

    property p_oe_drive;
        @(posedge i_mclk) disable iff (i_rst)
        o_sample_word_oe == {8{!i_output_enable_n}};
    endproperty
    a_oe_drive: assert property (p_oe_drive)
        else $error("output enable mismatch");

    property p_clamp;
        @(posedge i_mclk) disable iff (i_rst)
        (i_clamp_enable_n || i_clamp_pulse_n) |-> !o_clamp_active;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("clamp active while disabled");

    property p_clamp_hold;
        @(posedge i_mclk) disable iff (i_rst)
        (s_fall ##0 o_clamp_active) |=> st.held == $past(i_clamp_code);
    endproperty
    a_clamp_hold: assert property (p_clamp_hold)
        else $error("clamp level not taken");

    property p_sample;
        @(posedge i_mclk) disable iff (i_rst)
        (s_fall ##0 !o_clamp_active) |=> st.held == $past(i_analog_code);
    endproperty
    a_sample: assert property (p_sample)
        else $error("sample not taken on fall");

    property p_hold_steady;
        @(posedge i_mclk) disable iff (i_rst)
        !fall |=> $stable(st.held);
    endproperty
    a_hold_steady: assert property (p_hold_steady)
        else $error("sample changed without fall");

    property p_word_steady;
        @(posedge i_mclk) disable iff (i_rst)
        !rise |=> $stable(o_sample_word);
    endproperty
    a_word_steady: assert property (p_word_steady)
        else $error("word changed off rising edge");

    property p_push_word;
        @(posedge i_mclk) disable iff (i_rst)
        st.push |-> $past(rise);
    endproperty
    a_push_word: assert property (p_push_word)
        else $error("push not tied to rising edge");

    property p_overflow;
        @(posedge i_mclk) disable iff (i_rst)
        (st.push && !fifo_in_ready) |=> o_overflow;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not flagged");
endmodule // vadc_core

// ---- sim/vadc_cap_model.sv ----
// capture side model: sample clock, clamp pulse and word reads
`timescale 1ns/1ps
module vadc_cap_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_run, // clock runs
    input wire logic [8:0] i_per, // period in mclk cycles
    input wire logic i_clamp_n, // wanted clamp level
    input wire logic i_drain, // reads allowed
    input wire logic i_coin, // random stall bit
    output logic o_sample_clk,
    output logic o_clamp_pulse_n,
    output logic o_word_ready
);
    logic [8:0] cnt; // phase count
    logic [8:0] per; // period in use
    // clock stands low outside runs, stops only at a low phase
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt <= 9'h000;
            per <= 9'h006;
            o_sample_clk <= 1'b0;
            o_clamp_pulse_n <= 1'b1;
            o_word_ready <= 1'b0;
        end else begin
            o_word_ready <= i_drain & i_coin;
            if (cnt == 9'h000 && !i_run) begin
                o_sample_clk <= 1'b0;
            end else begin
                if (cnt == 9'h000) begin
                    per <= i_per;
                end
                cnt <= (cnt == per - 9'h001) ? 9'h000 : cnt + 9'h001;
                o_sample_clk <= cnt >= {1'b0, per[8:1]};
                // pulse retimed on the rising sample edge
                if (!o_sample_clk && cnt >= {1'b0, per[8:1]}) begin
                    o_clamp_pulse_n <= i_clamp_n;
                end
            end
        end
    end
endmodule // vadc_cap_model

// ---- sim/vadc_core_tb.sv ----
// testbench: scoreboard run of the converter digital side
`timescale 1ns/1ps
module vadc_core_tb;
    import vadc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_analog_code = 8'h00; // quantised input
    logic [7:0] i_clamp_code = 8'h10; // clamp level code
    logic i_clamp_enable_n = 1'b1;
    logic i_output_enable_n = 1'b0;
    logic run = 1'b0, drain = 1'b1, coin = 1'b1, clamp_n = 1'b1;
    logic [8:0] per = 9'h006; // sample period
    logic sample_clk, clamp_pulse_n, rdy, prev_clk = 1'b0;
    logic [7:0] o_sample_word, o_sample_word_oe, o_word_data;
    logic o_clamp_active, o_word_valid, o_overflow;
    logic [7:0] exp_q[$]; // expected fifo words
    logic [7:0] pin_q[$]; // expected pin words, one per rise
    logic pin_due = 1'b0; // pin word updated at the last edge
    logic [7:0] codes[4] = '{VADC_CODE_MIN, VADC_CODE_MAX, VADC_CODE_MID,
        8'h7F}; // scale points
    int seed = 32'h1de8, error_cnt = 0, cmp_count = 0, cyc = 0, nfall = 0;
    vadc_core uut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_sample_clk(sample_clk), .i_analog_code(i_analog_code),
        .i_clamp_code(i_clamp_code), .i_clamp_enable_n(i_clamp_enable_n),
        .i_clamp_pulse_n(clamp_pulse_n),
        .i_output_enable_n(i_output_enable_n),
        .o_sample_word(o_sample_word), .o_sample_word_oe(o_sample_word_oe),
        .o_clamp_active(o_clamp_active), .o_word_valid(o_word_valid),
        .i_word_ready(rdy), .o_word_data(o_word_data),
        .o_overflow(o_overflow));
    vadc_cap_model cap (.i_mclk(i_mclk), .i_rst(i_rst), .i_run(run),
        .i_per(per), .i_clamp_n(clamp_n), .i_drain(drain), .i_coin(coin),
        .o_sample_clk(sample_clk), .o_clamp_pulse_n(clamp_pulse_n),
        .o_word_ready(rdy));
    // 200 MHz clock
    always #2.5 i_mclk = ~i_mclk;
    task automatic chk(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (e !== g) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // wait for n more sample falls, bounded
    task automatic falls(input int n);
        int t;
        t = nfall + n;
        repeat (n * 500) if (nfall < t) @(posedge i_mclk);
    endtask
    ////////////////////////////////////////////////////////////////////
    // stimulus; each fall notes the word the design captures
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (!i_rst && prev_clk && !sample_clk) begin
            exp_q.push_back((!i_clamp_enable_n && !clamp_pulse_n) ?
                i_clamp_code : i_analog_code);
            pin_q.push_back(exp_q[$]); // same sample reaches the pins
            nfall <= nfall + 1;
            i_analog_code <= (nfall < 3) ? codes[nfall + 1] :
                8'($random(seed));
        end
        pin_due <= !i_rst && !prev_clk && sample_clk; // rise seen here
        prev_clk <= sample_clk;
        i_output_enable_n <= 1'($random(seed));
        coin <= 1'($random(seed));
        clamp_n <= 1'($random(seed));
    end
    // hang guard
    always @(posedge i_mclk) begin
        if (cyc > 20000) begin
            error_cnt++;
            results();
        end
    end
    // monitor: oldest note against each word read
    always @(posedge i_mclk) begin
        if (!i_rst && o_word_valid === 1'b1 && rdy === 1'b1) begin
            if (exp_q.size() == 0) chk("spare", 8'hXX, o_word_data);
            else chk("word", exp_q.pop_front(), o_word_data);
        end
        // pin word one edge after each rise, third sample back
        if (pin_due) chk("pin", pin_q.pop_front(), o_sample_word);
    end
    // pin enables and clamp switch, settled mid cycle
    always @(negedge i_mclk) begin
        if (!i_rst) begin
            chk("oe", {8{~i_output_enable_n}}, o_sample_word_oe);
            chk("clamp", {7'h00, ~i_clamp_enable_n & ~clamp_pulse_n},
                {7'h00, o_clamp_active});
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        // first three rises show the reset word: no sample reaches the pins before the fourth rise
        repeat (3) pin_q.push_back(VADC_WORD_RST);
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        run <= 1'b1;
        falls(40); // fastest rate, scale end codes
        for (int i = 0; i < 6; i++) begin
            per <= 9'(VADC_PER_MIN_CYC + ($random(seed) & 7));
            i_clamp_enable_n <= i[0];
            i_clamp_code <= 8'($random(seed));
            falls(30);
        end
        per <= 9'(VADC_PER_MAX_CYC); // slowest rate
        falls(4);
        run <= 1'b0;
        repeat (1000) @(posedge i_mclk);
        chk("valid", 8'h00, {7'h00, o_word_valid});
        chk("pending", 8'h03, 8'(exp_q.size()));
        chk("ovf", 8'h00, {7'h00, o_overflow});
        per <= 9'(VADC_PER_MIN_CYC);
        drain <= 1'b0;
        run <= 1'b1;
        falls(40);
        chk("ovf", 8'h01, {7'h00, o_overflow});
        chk("full", 8'h01, {7'h00, o_word_valid});
        results();
    end
endmodule // vadc_core_tb
